// File: shared/eewc_map.svh
// constants of the eeprom write control block
`ifndef EEWC_MAP_SVH
`define EEWC_MAP_SVH

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define EEWC_CLK_MHZ      20
`define EEWC_NS_PER_US    1000
`define EEWC_TWC_NS       5000000

// ----------------------------------------------------------------------
// device address byte
// ----------------------------------------------------------------------
`define EEWC_TYPE_ARRAY   4'hA
`define EEWC_TYPE_REG     4'hB
`define EEWC_DEVF_TYPE    7:4
`define EEWC_DEVF_CS      3:2
`define EEWC_DEVF_A16     1
`define EEWC_DEVF_DIR     0
`define EEWC_DIR_WRITE    1'b0

// ----------------------------------------------------------------------
// first word address byte, register regions
// ----------------------------------------------------------------------
`define EEWC_AHI_A15      7
`define EEWC_AHI_SEL      3:2
`define EEWC_SEL_REG      2'h2

// ----------------------------------------------------------------------
// byte framing and page walk
// ----------------------------------------------------------------------
`define EEWC_BITS_DATA    4'h8
`define EEWC_BITS_ACK     4'h9
`define EEWC_BIT_ZERO     4'h0
`define EEWC_BIT_ONE      4'h1
`define EEWC_PTR_ONE      8'h01
`define EEWC_WORD_LAST    6'h3F
`define EEWC_WORD_FIRST   6'h00
`define EEWC_WORD_ONE     6'h01
`define EEWC_LANES        4
`define EEWC_PAGE_ZONE    8:6
`define EEWC_PAGE_BYTES   256

// ----------------------------------------------------------------------
// ecc code word
// ----------------------------------------------------------------------
`define EEWC_ECC_LEN      38
`define EEWC_CHECK_ZERO   6'h00

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define EEWC_RST_BYTE     8'h00
`define EEWC_RST_PAGE     9'h000
`define EEWC_RST_CNT      32'h0000_0000
`define EEWC_RST_SYNC     5'h1F

`endif

// File: shared/eewc_pkg.sv
// types of the eeprom write control block
`default_nettype none
package eewc_pkg;

    // one physical array word: four bytes plus check bits
    typedef struct packed {
        logic [5:0]  check;
        logic [31:0] data;
    } eewc_word_s;

    // request to the array
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [14:0] word_addr;
        eewc_word_s  wdata;
    } eewc_arr_cmd_s;

    // byte write to a register region
    typedef struct packed {
        logic       valid;
        logic       is_config;
        logic [7:0] addr;
        logic [7:0] data;
    } eewc_reg_wr_s;

    typedef enum logic [2:0] {
        BUS_IDLE, BUS_DEV, BUS_AHI, BUS_ALO, BUS_DATA, BUS_SKIP
    } eewc_bus_e;

    typedef enum logic [1:0] {
        ENG_IDLE, ENG_SCAN, ENG_READ, ENG_MERGE
    } eewc_eng_e;

    typedef enum logic [1:0] {
        RGN_ARRAY, RGN_SECURITY, RGN_CONFIG, RGN_NONE
    } eewc_region_e;

endpackage : eewc_pkg
`default_nettype wire

// File: core/eewc_ecc.sv
// single error correcting code over one 32-bit array word
`timescale 1ns/1ps
`default_nettype none
`include "eewc_map.svh"

module eewc_ecc (
    // word in
    input  wire logic [31:0] data_in,
    input  wire logic [5:0]  check_in,
    // corrected data and freshly generated check bits
    output logic      [31:0] data_fix,
    output logic      [5:0]  check_gen
);

    // ------------------------------------------------------------------
    // hamming code, check bits at power-of-two positions
    // ------------------------------------------------------------------
    always_comb begin
        int         j;
        logic [5:0] syn;
        logic [5:0] gen;
        j   = 0;
        gen = `EEWC_CHECK_ZERO;
        syn = `EEWC_CHECK_ZERO;
        for (int p = 1; p <= `EEWC_ECC_LEN; p++) begin
            if ((p & (p - 1)) != 0) begin
                if (data_in[j]) begin
                    gen = gen ^ 6'(p);
                end
                j = j + 1;
            end
        end
        syn       = gen ^ check_in;
        check_gen = gen;
        data_fix  = data_in;
        j         = 0;
        for (int p = 1; p <= `EEWC_ECC_LEN; p++) begin
            if ((p & (p - 1)) != 0) begin
                if (syn == 6'(p)) begin
                    data_fix[j] = ~data_in[j];
                end
                j = j + 1;
            end
        end
    end

endmodule : eewc_ecc
`default_nettype wire

// File: core/eewc_top.sv
// write side of a two-wire serial eeprom: bus client, page buffer, program engine
// Functional notes
// - every byte is selected by a 17-bit word address
// - acknowledge matching device address, word address bytes and each data byte
// - stop launches a self-timed program cycle; all inputs ignored meanwhile
// - write to protected area programs nothing and leaves device ready at once
// - page write of 1 to 256 bytes within one page in one cycle
// - host may send up to 255 further bytes; each one is acknowledged
// - only the low eight address bits count up and wrap within the page
// - array word is four bytes plus six check bits; single errors corrected
// - every array program rewrites a whole 4-byte word with fresh check bits
// - no access is acknowledged from launching stop until cycle ends
// - address polling answers nack while programming and ack when done
// - scheme select bit picks pin protection or zone protection
// - pin mode: pin high protects the whole array, low protects nothing
// - pin high blocks security writes in any mode; never blocks configuration
// - pin sampled at stop; later changes do not touch a running cycle
// - protected write still acknowledged throughout; stop then skips programming
// - bit zero of the device address byte selects read or write
// - bus protocol reset only resets the serial interface
`timescale 1ns/1ps
`default_nettype none
`include "eewc_map.svh"

module eewc_top #(
    parameter int unsigned TWC_CYCLES = `EEWC_TWC_NS * `EEWC_CLK_MHZ / `EEWC_NS_PER_US
) (
    // clock and reset
    input  wire logic                     clock,
    input  wire logic                     sys_rst,
    // two-wire bus pins
    input  wire logic                     scl_in,
    input  wire logic                     sda_in,
    output logic                          sda_out,
    output logic                          sda_oe_n,
    // straps and protection
    input  wire logic                     wp_in,
    input  wire logic [1:0]               chip_sel,
    input  wire logic                     protect_scheme_select,
    input  wire logic [7:0]               zone_protect,
    // array port
    output eewc_pkg::eewc_arr_cmd_s       arr_cmd,
    input  wire eewc_pkg::eewc_word_s     arr_rd_word,
    // register regions and status
    output eewc_pkg::eewc_reg_wr_s        reg_wr,
    output logic                          busy
);

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [4:0] meta_q;
    logic [4:0] sync_q;
    logic       scl_prev_q;
    logic       sda_prev_q;
    logic       scl_s;
    logic       sda_s;
    logic       wp_s;
    logic [1:0] cs_s;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            meta_q     <= `EEWC_RST_SYNC;
            sync_q     <= `EEWC_RST_SYNC;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            meta_q     <= {chip_sel, wp_in, sda_in, scl_in};
            sync_q     <= meta_q;
            scl_prev_q <= sync_q[0];
            sda_prev_q <= sync_q[1];
        end
    end

    assign scl_s = sync_q[0];
    assign sda_s = sync_q[1];
    assign wp_s  = sync_q[2];
    assign cs_s  = sync_q[4:3];

    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;

    assign scl_rise  = scl_s & ~scl_prev_q;
    assign scl_fall  = ~scl_s & scl_prev_q;
    assign bus_start = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
    assign bus_stop  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

    // ------------------------------------------------------------------
    // serial client and page buffer
    // ------------------------------------------------------------------
    eewc_pkg::eewc_bus_e    bus_q,      bus_d;
    eewc_pkg::eewc_region_e region_q,   region_d;
    logic [3:0]             bit_cnt_q,  bit_cnt_d;
    logic [7:0]             shift_q,    shift_d;
    logic                   drive_q,    drive_d;
    logic [8:0]             page_q,     page_d;
    logic [7:0]             ptr_q,      ptr_d;
    logic [7:0]             start_lo_q, start_lo_d;
    logic                   got_data_q, got_data_d;
    logic [7:0]             buf_q [`EEWC_PAGE_BYTES];
    logic [7:0]             buf_d [`EEWC_PAGE_BYTES];
    logic [255:0]           valid_q,    valid_d;
    logic                   busy_q,     busy_d;
    logic                   launch_arr;
    logic                   launch_reg;
    logic                   arr_prot;

    // zone mode uses A16..A14, pin mode covers all of it
    assign arr_prot = protect_scheme_select ? zone_protect[page_q[`EEWC_PAGE_ZONE]]
                                            : wp_s;

    always_comb begin
        bus_d      = bus_q;
        region_d   = region_q;
        bit_cnt_d  = bit_cnt_q;
        shift_d    = shift_q;
        drive_d    = drive_q;
        page_d     = page_q;
        ptr_d      = ptr_q;
        start_lo_d = start_lo_q;
        got_data_d = got_data_q;
        buf_d      = buf_q;
        valid_d    = valid_q;
        launch_arr = 1'b0;
        launch_reg = 1'b0;
        if (bus_start) begin
            // start always restarts the interface, never the engine
            bus_d     = eewc_pkg::BUS_DEV;
            bit_cnt_d = `EEWC_BIT_ZERO;
            drive_d   = 1'b0;
        end else if (bus_stop) begin
            bus_d     = eewc_pkg::BUS_IDLE;
            drive_d   = 1'b0;
            if (bus_q == eewc_pkg::BUS_DATA && got_data_q && !busy_q) begin
                unique case (region_q)
                    eewc_pkg::RGN_ARRAY:    launch_arr = ~arr_prot;
                    eewc_pkg::RGN_SECURITY: launch_reg = ~wp_s;
                    eewc_pkg::RGN_CONFIG:   launch_reg = 1'b1;
                    eewc_pkg::RGN_NONE:     launch_reg = 1'b0;
                endcase
            end
        end else if (bus_q != eewc_pkg::BUS_IDLE && scl_rise
                     && bit_cnt_q < `EEWC_BITS_DATA) begin
            shift_d   = {shift_q[6:0], sda_s};
            bit_cnt_d = bit_cnt_q + `EEWC_BIT_ONE;
        end else if (bus_q != eewc_pkg::BUS_IDLE && scl_fall
                     && bit_cnt_q == `EEWC_BITS_ACK) begin
            drive_d   = 1'b0;
            bit_cnt_d = `EEWC_BIT_ZERO;
        end else if (bus_q != eewc_pkg::BUS_IDLE && scl_fall
                     && bit_cnt_q == `EEWC_BITS_DATA) begin
            bit_cnt_d = `EEWC_BITS_ACK;
            unique case (bus_q)
                eewc_pkg::BUS_DEV: begin
                    // busy device answers nothing at all
                    if (!busy_q && shift_q[`EEWC_DEVF_CS] == cs_s
                        && (shift_q[`EEWC_DEVF_TYPE] == `EEWC_TYPE_ARRAY
                            || shift_q[`EEWC_DEVF_TYPE] == `EEWC_TYPE_REG)) begin
                        drive_d = 1'b1;
                        if (shift_q[`EEWC_DEVF_DIR] == `EEWC_DIR_WRITE) begin
                            bus_d     = eewc_pkg::BUS_AHI;
                            page_d[8] = shift_q[`EEWC_DEVF_A16];
                            region_d  = (shift_q[`EEWC_DEVF_TYPE] == `EEWC_TYPE_ARRAY)
                                        ? eewc_pkg::RGN_ARRAY : eewc_pkg::RGN_NONE;
                        end else begin
                            bus_d = eewc_pkg::BUS_SKIP;
                        end
                    end else begin
                        bus_d = eewc_pkg::BUS_SKIP;
                    end
                end
                eewc_pkg::BUS_AHI: begin
                    drive_d     = 1'b1;
                    bus_d       = eewc_pkg::BUS_ALO;
                    page_d[7:0] = shift_q;
                    if (region_q != eewc_pkg::RGN_ARRAY) begin
                        if (shift_q[`EEWC_AHI_SEL] != `EEWC_SEL_REG) begin
                            region_d = eewc_pkg::RGN_NONE;
                        end else if (shift_q[`EEWC_AHI_A15]) begin
                            region_d = eewc_pkg::RGN_CONFIG;
                        end else begin
                            region_d = eewc_pkg::RGN_SECURITY;
                        end
                    end
                end
                eewc_pkg::BUS_ALO: begin
                    drive_d    = 1'b1;
                    bus_d      = eewc_pkg::BUS_DATA;
                    ptr_d      = shift_q;
                    start_lo_d = shift_q;
                    got_data_d = 1'b0;
                    valid_d    = '0;
                end
                eewc_pkg::BUS_DATA: begin
                    drive_d        = 1'b1;
                    buf_d[ptr_q]   = shift_q;
                    valid_d[ptr_q] = 1'b1;
                    ptr_d          = ptr_q + `EEWC_PTR_ONE;
                    got_data_d     = 1'b1;
                end
                eewc_pkg::BUS_SKIP,
                eewc_pkg::BUS_IDLE: begin
                    drive_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            bus_q      <= eewc_pkg::BUS_IDLE;
            region_q   <= eewc_pkg::RGN_NONE;
            bit_cnt_q  <= `EEWC_BIT_ZERO;
            shift_q    <= `EEWC_RST_BYTE;
            drive_q    <= 1'b0;
            page_q     <= `EEWC_RST_PAGE;
            ptr_q      <= `EEWC_RST_BYTE;
            start_lo_q <= `EEWC_RST_BYTE;
            got_data_q <= 1'b0;
            valid_q    <= '0;
            for (int i = 0; i < `EEWC_PAGE_BYTES; i++) begin
                buf_q[i] <= `EEWC_RST_BYTE;
            end
        end else begin
            bus_q      <= bus_d;
            region_q   <= region_d;
            bit_cnt_q  <= bit_cnt_d;
            shift_q    <= shift_d;
            drive_q    <= drive_d;
            page_q     <= page_d;
            ptr_q      <= ptr_d;
            start_lo_q <= start_lo_d;
            got_data_q <= got_data_d;
            valid_q    <= valid_d;
            buf_q      <= buf_d;
        end
    end

    // ------------------------------------------------------------------
    // word merge and check bit generation
    // ------------------------------------------------------------------
    logic [5:0]  word_idx_q, word_idx_d;
    logic [31:0] rd_fix;
    logic [31:0] merged;
    logic [5:0]  wr_check;
    logic [3:0]  lane_valid;

    always_comb begin
        logic [7:0] bi;
        bi     = `EEWC_RST_BYTE;
        merged = rd_fix;
        for (int k = 0; k < `EEWC_LANES; k++) begin
            bi            = {word_idx_q, 2'(k)};
            lane_valid[k] = valid_q[bi];
            if (valid_q[bi]) begin
                merged[8*k +: 8] = buf_q[bi];
            end
        end
    end

    eewc_ecc u_ecc_rd (
        .data_in   (arr_rd_word.data),
        .check_in  (arr_rd_word.check),
        .data_fix  (rd_fix),
        .check_gen ()
    );

    eewc_ecc u_ecc_wr (
        .data_in   (merged),
        .check_in  (`EEWC_CHECK_ZERO),
        .data_fix  (),
        .check_gen (wr_check)
    );

    // ------------------------------------------------------------------
    // program engine and write cycle timer
    // ------------------------------------------------------------------
    eewc_pkg::eewc_eng_e     eng_q,  eng_d;
    eewc_pkg::eewc_arr_cmd_s arr_q,  arr_d;
    eewc_pkg::eewc_reg_wr_s  reg_q,  reg_d;
    logic [31:0]             cnt_q,  cnt_d;

    always_comb begin
        eng_d      = eng_q;
        word_idx_d = word_idx_q;
        arr_d      = arr_q;
        arr_d.rd   = 1'b0;
        arr_d.wr   = 1'b0;
        reg_d      = reg_q;
        reg_d.valid = 1'b0;
        cnt_d      = cnt_q;
        if (launch_arr || launch_reg) begin
            cnt_d = TWC_CYCLES;
        end else if (cnt_q != `EEWC_RST_CNT) begin
            cnt_d = cnt_q - 32'h0000_0001;
        end
        if (launch_reg) begin
            reg_d.valid     = 1'b1;
            reg_d.is_config = (region_q == eewc_pkg::RGN_CONFIG);
            reg_d.addr      = start_lo_q;
            reg_d.data      = buf_q[start_lo_q];
        end
        unique case (eng_q)
            eewc_pkg::ENG_IDLE: begin
                if (launch_arr) begin
                    eng_d      = eewc_pkg::ENG_SCAN;
                    word_idx_d = `EEWC_WORD_FIRST;
                end
            end
            eewc_pkg::ENG_SCAN: begin
                if (lane_valid != 4'h0) begin
                    arr_d.rd        = 1'b1;
                    arr_d.word_addr = {page_q, word_idx_q};
                    eng_d           = eewc_pkg::ENG_READ;
                end else if (word_idx_q == `EEWC_WORD_LAST) begin
                    eng_d = eewc_pkg::ENG_IDLE;
                end else begin
                    word_idx_d = word_idx_q + `EEWC_WORD_ONE;
                end
            end
            eewc_pkg::ENG_READ: begin
                eng_d = eewc_pkg::ENG_MERGE;
            end
            eewc_pkg::ENG_MERGE: begin
                arr_d.wr          = 1'b1;
                arr_d.wdata.data  = merged;
                arr_d.wdata.check = wr_check;
                if (word_idx_q == `EEWC_WORD_LAST) begin
                    eng_d = eewc_pkg::ENG_IDLE;
                end else begin
                    eng_d      = eewc_pkg::ENG_SCAN;
                    word_idx_d = word_idx_q + `EEWC_WORD_ONE;
                end
            end
        endcase
        // engine outlasting a short timer still holds the device busy
        busy_d = (cnt_d != `EEWC_RST_CNT) || (eng_d != eewc_pkg::ENG_IDLE);
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            eng_q      <= eewc_pkg::ENG_IDLE;
            word_idx_q <= `EEWC_WORD_FIRST;
            arr_q      <= '0;
            reg_q      <= '0;
            cnt_q      <= `EEWC_RST_CNT;
            busy_q     <= 1'b0;
        end else begin
            eng_q      <= eng_d;
            word_idx_q <= word_idx_d;
            arr_q      <= arr_d;
            reg_q      <= reg_d;
            cnt_q      <= cnt_d;
            busy_q     <= busy_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    logic sda_out_q;
    logic sda_oe_n_q;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sda_out_q  <= 1'b0;
            sda_oe_n_q <= 1'b1;
        end else begin
            sda_out_q  <= 1'b0;
            sda_oe_n_q <= ~drive_d;
        end
    end

    assign sda_out  = sda_out_q;
    assign sda_oe_n = sda_oe_n_q;
    assign arr_cmd  = arr_q;
    assign reg_wr   = reg_q;
    assign busy     = busy_q;

endmodule : eewc_top
`default_nettype wire

// File: verif/eewc_top_assertions.sv
// port assertions of the eeprom write control block
`timescale 1ns/1ps
`default_nettype none
module eewc_chk #(
    parameter int unsigned TWC_CYCLES = 400
) (
    // clock and reset
    input wire logic                    clock,
    input wire logic                    sys_rst,
    // bus pins
    input wire logic                    scl_in,
    input wire logic                    sda_in,
    input wire logic                    sda_out,
    input wire logic                    sda_oe_n,
    // array, registers and status
    input wire eewc_pkg::eewc_arr_cmd_s arr_cmd,
    input wire eewc_pkg::eewc_reg_wr_s  reg_wr,
    input wire logic                    busy
);
    logic [16:0] bcnt_q, bcnt_d;
    logic [3:0]  stp_q, stp_d;
    logic        sda_q;
    // busy length, cycles since a stop on the pins
    always_comb begin
        bcnt_d = busy ? bcnt_q + 17'h1 : 17'h0;
        stp_d = (scl_in && sda_in && !sda_q) ? 4'h0 : stp_q + 4'(stp_q != 4'hF);
    end
    always_ff @(posedge clock) begin
        bcnt_q <= sys_rst ? 17'h0 : bcnt_d;
        stp_q <= sys_rst ? 4'hF : stp_d;
        sda_q <= sda_in;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    od_low_a: assert property (!sda_out)
        else $error("data pin driven high");
    busy_nack_a: assert property (busy |-> sda_oe_n)
        else $error("ack while busy");
    ack_hold_a: assert property ($fell(sda_oe_n) |-> !scl_in ##1 !sda_oe_n [*4])
        else $error("ack not held");
    wr_in_busy_a: assert property (arr_cmd.wr |-> busy)
        else $error("program outside busy");
    rd_wr_pair_a: assert property (arr_cmd.rd |-> ##2 (arr_cmd.wr &&
        arr_cmd.word_addr == $past(arr_cmd.word_addr, 2)))
        else $error("word not rewritten");
    reg_pulse_a: assert property (reg_wr.valid |-> busy ##1 !reg_wr.valid)
        else $error("register write pulse wrong");
    busy_len_a: assert property ($fell(busy) |-> bcnt_q >= TWC_CYCLES - 2 &&
        bcnt_q <= TWC_CYCLES + 200)
        else $error("busy length wrong");
    busy_launch_a: assert property ($rose(busy) |-> stp_q inside {[1:9]})
        else $error("busy without stop");
endmodule : eewc_chk
bind eewc_top eewc_chk #(.TWC_CYCLES(TWC_CYCLES)) eewc_chk_i (.clock, .sys_rst, .scl_in,
    .sda_in, .sda_out, .sda_oe_n, .arr_cmd, .reg_wr, .busy);
`default_nettype wire

// File: verif/eewc_host.sv
// two-wire bus host model
`timescale 1ns/1ps
`default_nettype none
module eewc_host (
    // clock and resolved data line
    input  wire logic clock,
    input  wire logic sda_line,
    // lines pulled low or released
    output logic      scl,
    output logic      sda_drv
);
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // quarter of a 1 MHz bit
    task automatic st(input logic c, input logic d);
        repeat (5) @(posedge clock);
        #5;
        scl = c;
        sda_drv = d;
    endtask : st
    task automatic start();
        st(1'b0, sda_drv);
        st(1'b0, 1'b1);
        st(1'b1, 1'b1);
        st(1'b1, 1'b0);
    endtask : start
    task automatic stop();
        st(1'b0, sda_drv);
        st(1'b0, 1'b0);
        st(1'b1, 1'b0);
        st(1'b1, 1'b1);
    endtask : stop
    // eight bits then a released ack slot
    task automatic wbyte(input logic [8:0] b, output logic ack);
        for (int i = 8; i >= 0; i--) begin
            st(1'b0, sda_drv);
            st(1'b0, b[i]);
            st(1'b1, b[i]);
            st(1'b1, b[i]);
            ack = ~sda_line;
        end
    endtask : wbyte
endmodule : eewc_host
`default_nettype wire

// File: verif/tb.sv
// self-checking bench of the eeprom write control block
`timescale 1ns/1ps
`default_nettype none
`include "eewc_map.svh"
module tb;
    localparam int TWC = 400;
    localparam logic [3:0] TA = `EEWC_TYPE_ARRAY;
    logic                    clock = 1'b0;
    logic                    sys_rst = 1'b1;
    logic                    wp_in = 1'b0;
    logic                    protect_scheme_select = 1'b0;
    logic [1:0]              chip_sel = 2'h1;
    logic [7:0]              zone_protect = 8'hFF;
    logic                    scl_in, sda_in, sda_drv, sda_out, sda_oe_n, busy;
    eewc_pkg::eewc_arr_cmd_s arr_cmd;
    eewc_pkg::eewc_reg_wr_s  reg_wr;
    eewc_pkg::eewc_word_s    rd_word = '0;
    eewc_pkg::eewc_word_s    mem [logic [14:0]];
    logic [47:0]             exp_q [$];
    logic [7:0]              tx_q [$];
    logic [7:0]              pd [8];
    int                      error_cnt = 0;
    int                      n_tests = 0;
    int                      cyc = 0;
    int                      seed = 32'h0000_6e7a;
    always #25 clock = ~clock;
    assign sda_in = sda_drv & (sda_oe_n | sda_out);
    eewc_top #(.TWC_CYCLES(TWC)) eewc_top_i (.clock, .sys_rst, .scl_in, .sda_in, .sda_out,
        .sda_oe_n, .wp_in, .chip_sel, .protect_scheme_select, .zone_protect, .arr_cmd,
        .arr_rd_word(rd_word), .reg_wr, .busy);
    eewc_host eewc_host_i (.clock, .sda_line(sda_in), .scl(scl_in), .sda_drv);
    task automatic cmp(input logic [47:0] e, input logic [47:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %0t exp %h got %h", $time, e, g);
        end
    endtask : cmp
    task automatic chk(input logic [47:0] g);
        cmp(exp_q.size() != 0 ? exp_q.pop_front() : 48'hx, g);
    endtask : chk
    task automatic summarize();
        if (error_cnt == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : summarize
    // array model, result watcher, run limit
    always @(posedge clock) begin
        rd_word <= ~rd_word;
        if (arr_cmd.rd)
            rd_word <= mem.exists(arr_cmd.word_addr) ? mem[arr_cmd.word_addr] : '0;
        if (arr_cmd.wr) begin
            mem[arr_cmd.word_addr] = arr_cmd.wdata;
            chk({1'b0, arr_cmd.word_addr, arr_cmd.wdata.data});
        end
        if (reg_wr.valid)
            chk({1'b1, 6'h0, reg_wr.is_config, reg_wr.addr, 24'h0, reg_wr.data});
        cyc++;
        if (cyc > 40000) begin
            error_cnt++;
            summarize();
        end
    end
    function automatic logic [7:0] dv(input logic [3:0] t, input logic a16);
        return {t, chip_sel, a16, 1'b0};
    endfunction : dv
    function automatic logic [47:0] aw(input logic [16:0] a, input logic [7:0] d);
        return {1'b0, a[16:2], 32'(d) << (8 * a[1:0])};
    endfunction : aw
    task automatic frame(input logic ea);
        logic a;
        eewc_host_i.start();
        foreach (tx_q[i]) begin
            eewc_host_i.wbyte({tx_q[i], 1'b1}, a);
            cmp(48'(ea), 48'(a));
        end
        eewc_host_i.stop();
        tx_q.delete();
    endtask : frame
    // address polling; busy expected means more than one attempt
    task automatic poll(input logic [7:0] v, input logic bz);
        logic a;
        int k;
        a = 1'b0;
        for (k = 0; k < 30 && !a; k++) begin
            eewc_host_i.start();
            eewc_host_i.wbyte({v, 1'b1}, a);
        end
        eewc_host_i.stop();
        cmp(48'({bz, 1'b1}), 48'({k > 1, a}));
    endtask : poll
    task automatic wr(input logic [7:0] v, input logic [15:0] a, input logic [7:0] d,
                      input logic [47:0] e, input logic pr);
        tx_q = '{v, a[15:8], a[7:0], d};
        if (pr)
            exp_q.push_back(e);
        frame(1'b1);
        poll(v, pr);
    endtask : wr
    initial begin
        logic [7:0] d;
        chip_sel = 2'($random(seed));
        repeat (6) @(posedge clock);
        #5;
        sys_rst = 1'b0;
        repeat (4) @(posedge clock);
        // byte write over a word holding a flipped bit, pin raised mid cycle
        d = 8'($random(seed));
        mem[15'h48D1] = {6'h00, 32'h0400_0000};
        fork
            wr(dv(TA, 1'b1), 16'h2345, d, aw(17'h1_2345, d), 1'b1);
            begin
                @(posedge busy);
                #5;
                wp_in = 1'b1;
            end
        join
        wr(dv(TA, 1'b0), 16'h0010, d, 48'h0, 1'b0);
        protect_scheme_select = 1'b1;
        zone_protect = 8'hFE;
        wr(dv(TA, 1'b0), 16'h0021, d, aw(17'h0_0021, d), 1'b1);
        zone_protect = 8'h01;
        wr(dv(TA, 1'b0), 16'h0021, d, 48'h0, 1'b0);
        protect_scheme_select = 1'b0;
        for (int i = 0; i < 6; i++) begin
            wp_in = i[1];
            d = 8'($random(seed));
            wr(dv(`EEWC_TYPE_REG, 1'b0), {i[0], 3'h0, ~i[2], i[2], 2'h0, 8'h05}, d,
               {1'b1, 6'h0, i[0], 8'h05, 24'h0, d}, (i[0] | ~i[1]) & ~i[2]);
        end
        // page write running past the page end
        wp_in = 1'b0;
        tx_q = '{dv(TA, 1'b0), 8'h07, 8'hFC};
        foreach (pd[i]) begin
            pd[i] = 8'($random(seed));
            tx_q.push_back(pd[i]);
        end
        exp_q.push_back({1'b0, 15'h01C0, pd[7], pd[6], pd[5], pd[4]});
        exp_q.push_back({1'b0, 15'h01FF, pd[3], pd[2], pd[1], pd[0]});
        frame(1'b1);
        poll(dv(TA, 1'b0), 1'b1);
        tx_q = '{{TA, ~chip_sel, 2'b00}};
        frame(1'b0);
        tx_q = '{{TA, chip_sel, 2'b01}};
        frame(1'b1);
        repeat (20) @(posedge clock);
        cmp(48'h0, 48'(exp_q.size()));
        summarize();
    end
endmodule : tb
`default_nettype wire
